// >>> afe_model.sv
// ==========
// Analog front end seen by the sequencer
module afe_model (
	input  logic [15:0] dac_trial_code,
	input  logic [15:0] level,
	output logic        comparator_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Held input at or above the trial weight keeps the bit; level is offset binary
	assign comparator_out = (dac_trial_code <= level);
endmodule // afe_model

// >>> conv_osc.v
// ==========================================================
// Conversion oscillator: tick every DIV cycles while run is high
module conv_osc #(
	parameter DIV = 4,
	parameter CW  = 8
) (
	input  wire clk,
	input  wire rst_n,
	input  wire run,
	output reg  tick
);
	reg [CW-1:0] cnt_reg;

	// Restarts from zero on each conversion so every trial gets full settling
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= {CW{1'b0}};
			tick    <= 1'b0;
		end else if (!run) begin
			cnt_reg <= {CW{1'b0}};
			tick    <= 1'b0;
		end else if (cnt_reg == DIV[CW-1:0] - 1'b1) begin
			cnt_reg <= {CW{1'b0}};
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick    <= 1'b0;
		end
	end
endmodule // conv_osc

// >>> sar_conversion_sequencer.v
//
// Contract
// - Start input rising edge ends acquisition, starts conversion
// - Binary search, sixteen trials, MSB first
// - After last trial form code, drop busy
// - Internal oscillator times trials, no serial clock
// - Result is two's complement around zero
// - Overrange saturates to 0x7FFF, span scales
// - Underrange saturates to 0x8000, span scales
// - Clamp engaged sets overvoltage flag
// - Flag sticky, cleared only by reading it
// - Clamp state also in result status bits
// - Span compression off after reset, writable
// - High-impedance mode off after reset, writable
//
// The APB slave port and the register addresses were chosen for this implementation.
`include "sar_seq_defines.vh"

module sar_conversion_sequencer #(
	parameter TRIAL_DIV = `TRIAL_DIV
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        conversion_start,
	input  wire        comparator_out,
	input  wire        clamp_active,
	output reg  [15:0] dac_trial_code,
	output reg         sample_hold,
	output reg         busy,
	output reg         span_compress_en,
	output reg         high_z_en,
	output reg         irq
);

	// ==========================================================
	// Pin synchronisation
	wire       start_sync;
	wire       comp_sync;
	wire       clamp_sync;
	reg        start_prev_reg;
	wire       start_rise;

	sync2 #(
		.W (3)
	) u_pin_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({conversion_start, comparator_out, clamp_active}),
		.q     ({start_sync, comp_sync, clamp_sync})
	);

	// Edge detect on the synchronised start level
	// Reset value matches the idle-low pin, so release gives no false edge
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_prev_reg <= 1'b0;
		end else begin
			start_prev_reg <= start_sync;
		end
	end

	assign start_rise = start_sync & ~start_prev_reg;

	// ==========================================================
	// Conversion state machine
	localparam ST_ACQ  = 2'd0;
	localparam ST_HOLD = 2'd1;
	localparam ST_CONV = 2'd2;

	reg  [1:0]  state_reg;
	reg  [1:0]  state_next;
	reg  [15:0] trial_reg;
	reg  [15:0] trial_next;
	reg  [15:0] mask_reg;
	reg  [15:0] mask_next;
	reg  [15:0] result_reg;
	reg  [15:0] result_next;
	reg         done_pulse;
	wire        osc_tick;
	wire        osc_run;
	wire        last_trial;

	assign osc_run    = (state_reg != ST_ACQ);
	// The lowest bit is the sixteenth and final trial
	assign last_trial = (mask_reg == 16'h0001);

	// Trial timing comes from its own divider, never from the bus; the
	// comparator reaches a decision two edges late through its synchroniser,
	// so a trial shorter than three cycles would judge a stale comparison
	conv_osc #(
		.DIV (TRIAL_DIV),
		.CW  (8)
	) u_conv_osc (
		.clk   (pclk),
		.rst_n (presetn),
		.run   (osc_run),
		.tick  (osc_tick)
	);

	// Next-state logic; comparator high means the input is at or above the trial
	always @* begin
		state_next  = state_reg;
		trial_next  = trial_reg;
		mask_next   = mask_reg;
		result_next = result_reg;
		done_pulse  = 1'b0;
		case (state_reg)
			ST_ACQ: begin
				if (start_rise) begin
					state_next = ST_HOLD;
					trial_next = `CODE_MSB_SET;
					mask_next  = `CODE_MSB_SET;
				end
			end
			ST_HOLD: begin
				// One oscillator period for the held charge to settle
				if (osc_tick) begin
					state_next = ST_CONV;
				end
			end
			ST_CONV: begin
				if (osc_tick) begin
					// Keep or drop the current bit, then try the next lower one
					if (!comp_sync) begin
						trial_next = trial_reg & ~mask_reg;
					end
					mask_next  = mask_reg >> 1;
					trial_next = trial_next | (mask_reg >> 1);
					if (last_trial) begin
						// Offset binary flipped to two's complement; all-ones and
						// all-zero searches land on the saturated end codes
						result_next = trial_next ^ `CODE_SIGN_FLIP;
						state_next  = ST_ACQ;
						done_pulse  = 1'b1;
					end
				end
			end
			default: begin
				state_next = ST_ACQ;
			end
		endcase
	end

	// Result only moves on completion, so readout is stable between ends
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= ST_ACQ;
			trial_reg      <= 16'h0000;
			mask_reg       <= 16'h0000;
			result_reg     <= 16'h0000;
			dac_trial_code <= 16'h0000;
			sample_hold    <= 1'b0;
			busy           <= 1'b0;
		end else begin
			state_reg      <= state_next;
			trial_reg      <= trial_next;
			mask_reg       <= mask_next;
			result_reg     <= result_next;
			dac_trial_code <= trial_next;
			sample_hold    <= (state_next != ST_ACQ);
			busy           <= (state_next != ST_ACQ);
		end
	end

	// ==========================================================
	// Configuration and overvoltage flag
	reg        ov_flag_reg;
	reg        ov_flag_next;
	reg [1:0]  irq_stat_reg;
	reg [1:0]  irq_stat_next;
	reg [1:0]  irq_mask_reg;
	wire       acc_edge;
	wire       wr_edge;
	wire       rd_edge;
	wire       ov_clear;
	wire       ctrl_wr;
	wire       irq_stat_wr;
	wire       irq_mask_wr;
	wire [1:0] irq_set;
	wire [1:0] irq_clr;

	// Access completes on the edge where pready is seen high
	assign acc_edge = psel & penable & pready;
	assign wr_edge  = acc_edge & pwrite;
	assign rd_edge  = acc_edge & ~pwrite;
	// Clear only a flag that the read actually returned; one raised after the
	// setup cycle was never seen and must stay up for the next read
	assign ov_clear = rd_edge & (paddr == `OFS_STATUS) & prdata[`STAT_OVFLG_BIT];

	// Write strobes, one per writable offset
	assign ctrl_wr     = wr_edge & (paddr == `OFS_CTRL);
	assign irq_stat_wr = wr_edge & (paddr == `OFS_IRQ_STAT);
	assign irq_mask_wr = wr_edge & (paddr == `OFS_IRQ_MASK);

	// Span and high-Z mode bits, both off out of reset
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			span_compress_en <= 1'b0;
			high_z_en        <= 1'b0;
		end else if (ctrl_wr) begin
			span_compress_en <= pwdata[`CTRL_SPAN_BIT];
			high_z_en        <= pwdata[`CTRL_HIGHZ_BIT];
		end
	end

	// Sticky flag: a clamp event in the clearing read's cycle survives
	always @* begin
		ov_flag_next = ov_flag_reg;
		if (clamp_sync) begin
			ov_flag_next = 1'b1;
		end else if (ov_clear) begin
			ov_flag_next = 1'b0;
		end
	end

	// Flag register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ov_flag_reg <= 1'b0;
		end else begin
			ov_flag_reg <= ov_flag_next;
		end
	end

	// ==========================================================
	// Interrupts: sticky, write one to clear, set wins
	assign irq_set = {clamp_sync & ~ov_flag_reg, done_pulse};
	assign irq_clr = irq_stat_wr ? pwdata[1:0] : 2'b00;

	// Set wins over a write-one clear in the same cycle; irq follows this
	// value, so the line drops at the edge that clears the last unmasked bit
	always @* begin
		irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
	end

	// Status, mask and the registered interrupt line
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= 2'b00;
			irq_mask_reg <= 2'b00;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (irq_mask_wr) begin
				irq_mask_reg <= pwdata[1:0];
			end
			irq <= |(irq_stat_next & irq_mask_reg);
		end
	end

	// ==========================================================
	// APB read mux and zero-wait-state answer
	reg [31:0] rd_data;
	reg        rd_err;

	// Address decode; unmapped offsets read zero and flag an error
	always @* begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		if (paddr == `OFS_CTRL) begin
			rd_data[`CTRL_SPAN_BIT]  = span_compress_en;
			rd_data[`CTRL_HIGHZ_BIT] = high_z_en;
		end else if (paddr == `OFS_STATUS) begin
			rd_data[`STAT_BUSY_BIT]  = busy;
			rd_data[`STAT_CLAMP_BIT] = clamp_sync;
			rd_data[`STAT_OVFLG_BIT] = ov_flag_reg;
		end else if (paddr == `OFS_RESULT) begin
			rd_data[15:0]           = result_reg;
			rd_data[`RES_OVFLG_BIT] = ov_flag_reg;
			rd_data[`RES_CLAMP_BIT] = clamp_sync;
			rd_data[`RES_SPAN_BIT]  = span_compress_en;
			rd_data[`RES_HIGHZ_BIT] = high_z_en;
		end else if (paddr == `OFS_IRQ_STAT) begin
			rd_data[1:0] = irq_stat_reg;
		end else if (paddr == `OFS_IRQ_MASK) begin
			rd_data[1:0] = irq_mask_reg;
		end else begin
			rd_err = 1'b1;
		end
	end

	// Answer is registered in the setup cycle, so pready rises in the
	// first access cycle; adds no wait state and keeps outputs on flops
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			prdata  <= pwrite ? 32'h0000_0000 : rd_data;
			pready  <= 1'b1;
			pslverr <= rd_err;
		end else begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule // sar_conversion_sequencer

// >>> sar_seq_chk.sv
// ==========
// Port checker for the conversion sequencer
module sar_seq_chk #(
	parameter TRIAL_DIV = 4
) (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        pslverr,
	input logic        conversion_start,
	input logic        comparator_out,
	input logic        clamp_active,
	input logic [15:0] dac_trial_code,
	input logic        sample_hold,
	input logic        busy,
	input logic        span_compress_en,
	input logic        high_z_en,
	input logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Completed writes; mode pins may follow one or two edges later
	wire apb_wr = psel && penable && pready && pwrite;
	wire ctl_wr = apb_wr && paddr == 8'h00;
	// Busy length in cycles, read when busy falls
	logic [15:0] busy_cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_cnt <= 16'h0000;
		end else if (busy) begin
			busy_cnt <= busy_cnt + 16'h0001;
		end else begin
			busy_cnt <= 16'h0000;
		end
	end
	property p_busy_len; $fell(busy) |-> busy_cnt == 17 * TRIAL_DIV + 1; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length");
	property p_start_load; $rose(busy) |-> sample_hold && dac_trial_code == 16'h8000; endproperty
	a_start_load: assert property (p_start_load) else $error("start load");
	property p_busy_min; $rose(busy) |-> busy[*8]; endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy short");
	property p_busy_end; $rose(busy) |-> ##[17:300] !busy; endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy end");
	property p_hold_fall; $fell(busy) |-> !sample_hold; endproperty
	a_hold_fall: assert property (p_hold_fall) else $error("hold fall");
	property p_dac_nz; busy |-> dac_trial_code != 16'h0000; endproperty
	a_dac_nz: assert property (p_dac_nz) else $error("no trial bit");
	property p_span; $changed(span_compress_en) |-> $past(ctl_wr) || $past(ctl_wr, 2); endproperty
	a_span: assert property (p_span) else $error("span change");
	property p_hz; $changed(high_z_en) |-> $past(ctl_wr) || $past(ctl_wr, 2); endproperty
	a_hz: assert property (p_hz) else $error("high z change");
	property p_irq_clr; $fell(irq) |-> $past(apb_wr) || $past(apb_wr, 2); endproperty
	a_irq_clr: assert property (p_irq_clr) else $error("irq fell");
	c_done: cover property ($fell(busy));
	c_irq: cover property ($rose(irq));
	c_err: cover property (pready && pslverr);
endmodule // sar_seq_chk

bind sar_conversion_sequencer sar_seq_chk #(.TRIAL_DIV(TRIAL_DIV)) i_chk (.*);

// >>> sar_seq_defines.vh
`ifndef SAR_SEQ_DEFINES_VH
`define SAR_SEQ_DEFINES_VH

// ==========================================================
// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_RESULT      8'h08
`define OFS_IRQ_STAT    8'h0c
`define OFS_IRQ_MASK    8'h10

// ==========================================================
// Control register fields
`define CTRL_SPAN_BIT   0
`define CTRL_HIGHZ_BIT  1
`define CTRL_RESET_VAL  2'h0

// ==========================================================
// Status register fields
`define STAT_BUSY_BIT   0
`define STAT_CLAMP_BIT  1
`define STAT_OVFLG_BIT  2

// ==========================================================
// Result register: code in low half, status bits above it
`define RES_CODE_LSB    0
`define RES_OVFLG_BIT   16
`define RES_CLAMP_BIT   17
`define RES_SPAN_BIT    18
`define RES_HIGHZ_BIT   19

// ==========================================================
// Interrupt fields, same layout in status and mask
`define IRQ_DONE_BIT    0
`define IRQ_OV_BIT      1
`define IRQ_WIDTH       2

// ==========================================================
// Converter constants
`define CODE_BITS       16
`define CODE_MSB_SET    16'h8000
`define CODE_SIGN_FLIP  16'h8000

// ==========================================================
// Timing: bit-trial period of the internal oscillator
`define PCLK_PERIOD_NS  10
`define TRIAL_PERIOD_NS 40
`define TRIAL_DIV       ((`TRIAL_PERIOD_NS + `PCLK_PERIOD_NS - 1) / `PCLK_PERIOD_NS)

`endif

// >>> sync2.v
// ==========================================================
// Two-stage synchroniser for asynchronous pins
module sync2 #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);
	reg [W-1:0] meta_reg;
	reg [W-1:0] sync_reg;

	// First stage feeds only the second stage
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= {W{1'b0}};
			sync_reg <= {W{1'b0}};
		end else begin
			meta_reg <= d;
			sync_reg <= meta_reg;
		end
	end

	assign q = sync_reg;
endmodule // sync2

// >>> testbench.sv
// ==========
// Self-checking bench for the conversion sequencer
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, conversion_start = 0, comparator_out, clamp_active = 0;
	logic [15:0] dac_trial_code, lvl = 16'h8000, last = 16'h0000;
	logic        sample_hold, busy, span_compress_en, high_z_en, irq;
	logic [15:0] corner [5] = '{16'h8000, 16'h8001, 16'h7fff, 16'hffff, 16'h0000};
	int          miscompares = 0, tests_run = 0, i, seed = 32'he146;
	// Clock
	always #5 pclk = ~pclk;
	// Short trial period keeps each conversion near fifty cycles
	sar_conversion_sequencer #(.TRIAL_DIV(3)) i_sar_conversion_sequencer (.*);
	afe_model i_afe_model (.dac_trial_code(dac_trial_code), .level(lvl), .comparator_out(comparator_out));
	// ==========
	// Helpers
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Setup, access, wait for pready at an edge, then release
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Offset-binary level to two's complement: flip the sign bit
	function logic [15:0] exp_code(input logic [15:0] l);
		return l ^ 16'h8000;
	endfunction
	// Old result stands while busy; a second rise during busy must not retrigger
	task convert(input logic [15:0] l);
		lvl <= l;
		@(posedge pclk);
		conversion_start <= 1;
		while (busy !== 1'b1) @(posedge pclk);
		conversion_start <= 0;
		apb(0, 8'h08, 0);
		chk(rd[15:0], last, "held busy");
		apb(0, 8'h04, 0);
		chk(rd[0], 1, "busy bit");
		conversion_start <= 1;
		while (busy !== 1'b0) @(posedge pclk);
		repeat (8) @(posedge pclk);
		chk(busy, 0, "busy");
		conversion_start <= 0;
		apb(0, 8'h08, 0);
		last = exp_code(l);
		chk(rd[15:0], last, "code");
		chk(irq, 1, "irq done");
		apb(1, 8'h0c, 32'h1);
		repeat (2) @(posedge pclk);
		chk(irq, 0, "irq clear");
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// ==========
	// Main sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h00, 0);
		chk(rd, 0, "ctrl");
		chk({span_compress_en, high_z_en}, 0, "modes");
		apb(1, 8'h00, 32'h3);
		@(posedge pclk);
		chk({span_compress_en, high_z_en}, 2'b11, "modes");
		apb(0, 8'h20, 0);
		chk(err, 1, "unmapped");
		apb(1, 8'h10, 32'h1);
		$display("test regs done");
		for (i = 0; i < 10; i++) convert(i < 5 ? corner[i] : 16'($random(seed)));
		last = exp_code(lvl);
		lvl <= ~lvl;
		repeat (5) @(posedge pclk);
		apb(0, 8'h08, 0);
		chk(rd[15:0], last, "held");
		$display("test conversions done");
		clamp_active <= 1;
		repeat (6) @(posedge pclk);
		apb(0, 8'h08, 0);
		chk(rd[17:16], 2'b11, "clamp");
		clamp_active <= 0;
		repeat (6) @(posedge pclk);
		apb(0, 8'h08, 0);
		chk(rd[17:16], 2'b01, "flag held");
		chk(irq, 0, "irq masked");
		apb(0, 8'h04, 0);
		chk(rd[2], 1, "flag");
		apb(0, 8'h04, 0);
		chk(rd[2], 0, "flag read");
		apb(1, 8'h10, 32'h3);
		repeat (2) @(posedge pclk);
		chk(irq, 1, "irq ov");
		$display("test clamp done");
		finish_test();
	end
	// Watchdog, far beyond the run of about eight hundred cycles
	initial begin
		#100us;
		miscompares++;
		finish_test();
	end
endmodule // testbench
